// file: verilog/amp_soft_control_sequencing.v
// Host-side bring-up and tear-down controller for a software-mode amplifier.
`timescale 1ns/1ps
`default_nettype none
`include "amp_seq_regs.vh"

// Notes on behaviour
// [R1] Threshold bits 5:0 written into device clip-low register bits 7:2.
// [R2] Clip-low register bits 1:0 always written as zero.
// [R3] Full 20-bit threshold split over high, middle and low registers.
// [R4] Gain select driven to 11; bridge pin doubles as pulled-up clock line.
// [R5] Shutdown held low while supplies are enabled and rising.
// [R6] Audio clocks started only after supplies report stable.
// [R7] Device programmed and muted while still in shutdown.
// [R8] Shutdown released only after clocks settle and programming finishes.
// [R9] Unmute over the control port after shutdown is released.
// [R10] Power down mutes first, then drives shutdown low.
// [R11] Clocks stop and supplies drop only after shutdown is low.
// [R12] Control registers other than the mute register are written only while shutdown is low.
// [R13] Device sleeps when shutdown pin low or its shutdown bit cleared.
// [R14] Latched overcurrent fault cleared by toggling shutdown low then high.
module amp_soft_control_sequencing (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    input wire supplyGood,
    input wire overcurrentFault,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    output wire sclOut,
    output wire sclOe,
    output reg supplyEnable_r,
    output reg audioClockEnable_r,
    output reg speakerShutdownN_r,
    output reg [1:0] speakerGainSelect_r
);
    localparam [3:0] S_OFF = 4'h0;
    localparam [3:0] S_SUPPLY = 4'h1;
    localparam [3:0] S_CLKSET = 4'h2;
    localparam [3:0] S_PROG = 4'h3;
    localparam [3:0] S_RELEASE = 4'h4;
    localparam [3:0] S_UNMUTE = 4'h5;
    localparam [3:0] S_RUN = 4'h6;
    localparam [3:0] S_MUTE = 4'h7;
    localparam [3:0] S_SDLOW = 4'h8;
    localparam [3:0] S_PWROFF = 4'h9;
    localparam [3:0] S_RECOVER = 4'hA;
    localparam integer SETTLE_I = `CLK_SETTLE_CYC;
    localparam integer SDHOLD_I = `SD_HOLD_CYC;
    localparam [15:0] SETTLE = SETTLE_I[15:0];
    localparam [15:0] SDHOLD = SDHOLD_I[15:0];

    reg [3:0] state_r;
    reg [15:0] wait_r;
    reg [1:0] step_r;
    reg issued_r;
    reg startEng_r;
    reg [7:0] wrReg_r;
    reg [7:0] wrData_r;
    reg [19:0] clip_r;
    reg [31:0] devCfg_r;
    reg [31:0] muteCfg_r;
    reg nackSticky_r;
    reg cmdUp_r;
    reg cmdDown_r;
    reg cmdRecover_r;
    reg [31:0] rdMux;
    reg mapped;

    wire engBusy;
    wire engDone;
    wire engNack;
    wire apbWrite;
    wire waitDone;
    wire [7:0] clipHi;
    wire [7:0] clipMid;
    wire [7:0] clipLow;
    wire [7:0] muteReg;

    assign apbWrite = psel && penable && pready_r && pwrite && mapped;
    assign waitDone = (wait_r == 16'h0000);
    assign clipHi = {2'h0, clip_r[19:14]}; // see [R3]
    assign clipMid = clip_r[13:6]; // see [R3]
    assign clipLow = {clip_r[5:0], 2'h0}; // see [R1] see [R2]
    assign muteReg = devCfg_r[23:16];
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;

    ctrl_port_writer u_writer (
        .clk(clk),
        .srst(srst),
        .start(startEng_r),
        .devAddr(devCfg_r[6:0]),
        .regAddr(wrReg_r),
        .regData(wrData_r),
        .sdaIn(sdaIn),
        .busy(engBusy),
        .done_r(engDone),
        .nack_r(engNack),
        .sclOe_r(sclOe),
        .sdaOe_r(sdaOe)
    );

    // APB decode: zero wait states, the access phase always completes.
    always @* begin
        mapped = 1'b1;
        rdMux = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL: rdMux = 32'h0000_0000;
            `OFS_STATUS: rdMux = {25'h0000000, overcurrentFault,
                                  nackSticky_r, (state_r != S_OFF &&
                                  state_r != S_RUN), state_r};
            `OFS_CLIP: rdMux = {12'h000, clip_r};
            `OFS_DEVCFG: rdMux = devCfg_r;
            `OFS_MUTECFG: rdMux = muteCfg_r;
            default: mapped = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            clip_r <= `RST_CLIP;
            devCfg_r <= `RST_DEVCFG;
            muteCfg_r <= `RST_MUTECFG;
            nackSticky_r <= 1'b0;
            cmdUp_r <= 1'b0;
            cmdDown_r <= 1'b0;
            cmdRecover_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_r <= mapped ? rdMux : 32'h0000_0000;
            end
            cmdUp_r <= apbWrite && paddr == `OFS_CTRL && pwdata[`CTRL_UP];
            cmdDown_r <= apbWrite && paddr == `OFS_CTRL && pwdata[`CTRL_DOWN];
            cmdRecover_r <= apbWrite && paddr == `OFS_CTRL &&
                            pwdata[`CTRL_RECOVER];
            // New values reach the device at the next bring-up; the mute value also at the next power down.
            if (apbWrite && paddr == `OFS_CLIP) begin
                clip_r <= pwdata[19:0];
            end
            if (apbWrite && paddr == `OFS_DEVCFG) begin
                devCfg_r <= pwdata;
            end
            if (apbWrite && paddr == `OFS_MUTECFG) begin
                muteCfg_r <= pwdata;
            end
            // A new failure in the clearing cycle keeps the flag set.
            if (engDone && engNack) begin
                nackSticky_r <= 1'b1;
            end else if (apbWrite && paddr == `OFS_STATUS &&
                         pwdata[`STAT_NACK]) begin
                nackSticky_r <= 1'b0;
            end
        end
    end

    // Sequencer. Register writes are issued one at a time: a start pulse
    // when the writer is idle, then the step advances on its done pulse.
    always @(posedge clk) begin
        if (srst) begin
            state_r <= S_OFF;
            wait_r <= 16'h0000;
            step_r <= 2'h0;
            issued_r <= 1'b0;
            startEng_r <= 1'b0;
            wrReg_r <= 8'h00;
            wrData_r <= 8'h00;
            supplyEnable_r <= 1'b0;
            audioClockEnable_r <= 1'b0;
            speakerShutdownN_r <= 1'b0;
            speakerGainSelect_r <= `GAIN_SOFT_MODE;
        end else begin
            startEng_r <= 1'b0;
            speakerGainSelect_r <= `GAIN_SOFT_MODE; // see [R4]
            if (!waitDone) begin
                wait_r <= wait_r - 16'h0001;
            end
            if (engDone) begin
                issued_r <= 1'b0;
            end
            case (state_r)
                S_OFF: begin
                    speakerShutdownN_r <= 1'b0; // see [R5]
                    if (cmdUp_r) begin
                        supplyEnable_r <= 1'b1; // see [R5]
                        state_r <= S_SUPPLY;
                    end
                end
                S_SUPPLY: begin
                    if (supplyGood) begin
                        audioClockEnable_r <= 1'b1; // see [R6]
                        wait_r <= SETTLE;
                        state_r <= S_CLKSET;
                    end
                end
                S_CLKSET: begin
                    if (waitDone) begin
                        step_r <= 2'h0;
                        state_r <= S_PROG;
                    end
                end
                S_PROG: begin
                    // Shutdown is still low here, so every write is legal.
                    if (!issued_r && !engBusy && !startEng_r) begin
                        issued_r <= 1'b1;
                        startEng_r <= 1'b1; // see [R12]
                        case (step_r)
                            2'h0: begin
                                wrReg_r <= devCfg_r[15:8];
                                wrData_r <= clipHi; // see [R3]
                            end
                            2'h1: begin
                                wrReg_r <= `DEV_CLIP_MID;
                                wrData_r <= clipMid;
                            end
                            2'h2: begin
                                wrReg_r <= `DEV_CLIP_LOW;
                                wrData_r <= clipLow; // see [R1]
                            end
                            default: begin
                                wrReg_r <= muteReg;
                                wrData_r <= muteCfg_r[7:0]; // see [R7]
                            end
                        endcase
                    end
                    if (engDone) begin
                        step_r <= step_r + 2'h1;
                        if (step_r == 2'h3) begin
                            speakerShutdownN_r <= 1'b1; // see [R8]
                            wait_r <= SDHOLD;
                            state_r <= S_RELEASE;
                        end
                    end
                end
                S_RELEASE: begin
                    if (waitDone && !engBusy) begin
                        wrReg_r <= muteReg;
                        wrData_r <= muteCfg_r[15:8];
                        startEng_r <= 1'b1; // see [R9]
                        issued_r <= 1'b1;
                        state_r <= S_UNMUTE;
                    end
                end
                S_UNMUTE: begin
                    if (engDone) begin
                        state_r <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (cmdDown_r) begin
                        wrReg_r <= muteReg;
                        wrData_r <= muteCfg_r[7:0];
                        startEng_r <= 1'b1; // see [R10]
                        issued_r <= 1'b1;
                        state_r <= S_MUTE;
                    end else if (cmdRecover_r) begin
                        speakerShutdownN_r <= 1'b0; // see [R14]
                        wait_r <= SDHOLD;
                        state_r <= S_RECOVER;
                    end
                end
                S_RECOVER: begin
                    if (waitDone) begin
                        speakerShutdownN_r <= 1'b1; // see [R14]
                        state_r <= S_RUN;
                    end
                end
                S_MUTE: begin
                    if (engDone) begin
                        speakerShutdownN_r <= 1'b0; // see [R10] see [R13]
                        wait_r <= SDHOLD;
                        state_r <= S_SDLOW;
                    end
                end
                S_SDLOW: begin
                    if (waitDone) begin
                        audioClockEnable_r <= 1'b0; // see [R11]
                        wait_r <= SDHOLD;
                        state_r <= S_PWROFF;
                    end
                end
                S_PWROFF: begin
                    if (waitDone) begin
                        supplyEnable_r <= 1'b0; // see [R11]
                        state_r <= S_OFF;
                    end
                end
                default: state_r <= S_OFF;
            endcase
        end
    end
endmodule // amp_soft_control_sequencing

`default_nettype wire

// file: pkg/amp_seq_regs.vh
// Constants of the amplifier bring-up controller: register map and timing.
`ifndef AMP_SEQ_REGS_VH
`define AMP_SEQ_REGS_VH

`define CLK_MHZ 200
// APB register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CLIP 8'h08
`define OFS_DEVCFG 8'h0C
`define OFS_MUTECFG 8'h10
// CTRL command bits (write one to issue).
`define CTRL_UP 0
`define CTRL_DOWN 1
`define CTRL_RECOVER 2
// STATUS fields.
`define STAT_STATE_HI 3
`define STAT_BUSY 4
`define STAT_NACK 5
`define STAT_FAULT 6
// Reset values.
`define RST_CLIP 20'h00000
`define RST_DEVCFG 32'h0000_0000
`define RST_MUTECFG 32'h0000_0000
// Device control-port register addresses.
`define DEV_CLIP_MID 8'h10
`define DEV_CLIP_LOW 8'h11
// Software-control strap value for the gain select pins.
`define GAIN_SOFT_MODE 2'h3
// Timing, in ns, and cycle counts derived from the clock rate.
`define I2C_QUARTER_NS 625
`define I2C_QUARTER_CYC ((`I2C_QUARTER_NS * `CLK_MHZ) / 1000)
`define CLK_SETTLE_NS 10000
`define CLK_SETTLE_CYC ((`CLK_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SD_HOLD_NS 1000
`define SD_HOLD_CYC ((`SD_HOLD_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: verilog/ctrl_port_writer.v
// Control-port master: one three-byte write (address, register, data).
`timescale 1ns/1ps
`default_nettype none
`include "amp_seq_regs.vh"

module ctrl_port_writer (
    input wire clk,
    input wire srst,
    input wire start,
    input wire [6:0] devAddr,
    input wire [7:0] regAddr,
    input wire [7:0] regData,
    input wire sdaIn,
    output wire busy,
    output reg done_r,
    output reg nack_r,
    output reg sclOe_r,
    output reg sdaOe_r
);
    localparam [1:0] W_IDLE = 2'h0;
    localparam [1:0] W_START = 2'h1;
    localparam [1:0] W_BIT = 2'h2;
    localparam [1:0] W_STOP = 2'h3;
    localparam integer QCYC = `I2C_QUARTER_CYC - 1;
    localparam [15:0] QMAX = QCYC[15:0];

    reg [1:0] st_r;
    reg [1:0] phase_r;
    reg [4:0] bitIdx_r;
    reg [26:0] shift_r;
    reg [15:0] qCnt_r;
    wire tick;
    wire ackSlot;

    assign busy = (st_r != W_IDLE);
    assign tick = busy && (qCnt_r == QMAX);
    assign ackSlot = (bitIdx_r == 5'h08) || (bitIdx_r == 5'h11) ||
                     (bitIdx_r == 5'h1A);

    // Lines are open drain: an enable pulls the line low, release lets it rise.
    always @(posedge clk) begin
        if (srst) begin
            st_r <= W_IDLE;
            phase_r <= 2'h0;
            bitIdx_r <= 5'h00;
            shift_r <= 27'h0000000;
            qCnt_r <= 16'h0000;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            sclOe_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            qCnt_r <= (!busy || tick) ? 16'h0000 : qCnt_r + 16'h0001;
            if (tick) begin
                phase_r <= phase_r + 2'h1;
            end
            case (st_r)
                W_IDLE: begin
                    if (start) begin
                        shift_r <= {devAddr, 1'b0, 1'b1, regAddr, 1'b1,
                                    regData, 1'b1};
                        nack_r <= 1'b0;
                        phase_r <= 2'h0;
                        st_r <= W_START;
                    end
                end
                W_START: begin
                    if (tick && phase_r == 2'h0) begin
                        sdaOe_r <= 1'b1;
                    end else if (tick && phase_r == 2'h1) begin
                        sclOe_r <= 1'b1;
                        bitIdx_r <= 5'h00;
                        phase_r <= 2'h0;
                        st_r <= W_BIT;
                    end
                end
                W_BIT: begin
                    if (tick) begin
                        case (phase_r)
                            2'h0: sdaOe_r <= ~shift_r[26];
                            2'h1: sclOe_r <= 1'b0;
                            2'h2: begin
                                if (ackSlot && sdaIn) begin
                                    nack_r <= 1'b1;
                                end
                            end
                            default: begin
                                sclOe_r <= 1'b1;
                                shift_r <= {shift_r[25:0], 1'b1};
                                bitIdx_r <= bitIdx_r + 5'h01;
                                if (bitIdx_r == 5'h1A) begin
                                    st_r <= W_STOP;
                                end
                            end
                        endcase
                    end
                end
                W_STOP: begin
                    if (tick) begin
                        case (phase_r)
                            2'h0: sdaOe_r <= 1'b1;
                            2'h1: sclOe_r <= 1'b0;
                            2'h2: sdaOe_r <= 1'b0;
                            default: begin
                                done_r <= 1'b1;
                                st_r <= W_IDLE;
                            end
                        endcase
                    end
                end
                default: st_r <= W_IDLE;
            endcase
        end
    end
endmodule // ctrl_port_writer

`default_nettype wire

// file: tb/amp_seq_props.sv
// Checker of the bring-up controller's pin ordering and bus answers.
`timescale 1ns/1ps
`default_nettype none
module amp_seq_props (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready_r,
    input wire pslverr_r,
    input wire supplyGood,
    input wire sdaOe,
    input wire sclOe,
    input wire supplyEnable_r,
    input wire audioClockEnable_r,
    input wire speakerShutdownN_r,
    input wire [1:0] speakerGainSelect_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_gain_strap: assert property (
        speakerGainSelect_r == 2'h3)
        else $error("Gain select left the software mode value.");
    a_supply_sd_low: assert property (
        $rose(supplyEnable_r) |-> !speakerShutdownN_r && !audioClockEnable_r)
        else $error("Supplies enabled with shutdown released.");
    a_clk_after_good: assert property (
        $rose(audioClockEnable_r) |-> supplyEnable_r && $past(supplyGood))
        else $error("Clocks started before supplies were stable.");
    a_sd_needs_clk: assert property (
        speakerShutdownN_r |-> audioClockEnable_r && supplyEnable_r)
        else $error("Shutdown released without clocks and supplies.");
    a_release_idle: assert property (
        $rose(speakerShutdownN_r) |-> !sclOe && !sdaOe
            && $past(audioClockEnable_r, 300))
        else $error("Shutdown released during programming.");
    a_clk_off_late: assert property (
        $fell(audioClockEnable_r) && !$past(srst) |-> supplyEnable_r
            && $past(!speakerShutdownN_r, 150))
        else $error("Clocks stopped too soon after shutdown.");
    a_supply_off_late: assert property (
        $fell(supplyEnable_r) && !$past(srst) |-> !audioClockEnable_r
            && $past(!audioClockEnable_r, 150))
        else $error("Supplies dropped with clocks running.");
    a_sd_low_hold: assert property (
        $fell(speakerShutdownN_r) && !$past(srst) |-> !speakerShutdownN_r[*8])
        else $error("Shutdown low pulse too short.");
    a_pready_zero: assert property (
        psel && !penable |=> pready_r)
        else $error("Access cycle without ready.");
    a_unmapped_err: assert property (
        psel && penable && paddr > 8'h10 |-> pslverr_r)
        else $error("Unmapped access without slave error.");
endmodule // amp_seq_props

bind amp_soft_control_sequencing amp_seq_props i_props (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .supplyGood(supplyGood),
    .sdaOe(sdaOe), .sclOe(sclOe), .supplyEnable_r(supplyEnable_r),
    .audioClockEnable_r(audioClockEnable_r),
    .speakerShutdownN_r(speakerShutdownN_r),
    .speakerGainSelect_r(speakerGainSelect_r));
`default_nettype wire

// file: tb/amp_device_model.sv
// Behavioural amplifier: control-port slave, clip fields, shutdown, fault.
`timescale 1ns/1ps
`default_nettype none
module amp_device_model #(
    parameter logic [6:0] ADDR = 7'h2C,
    parameter logic [7:0] MUTE_REG = 8'h07,
    parameter logic [7:0] CLIP_HI = 8'h0F,
    parameter logic [7:0] MUTE_VAL = 8'h11,
    parameter logic [7:0] SD_REG = 8'h03
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic shutdownN,
    input wire logic ocEvent,
    output logic sdaPull,
    output logic faultLatched,
    output logic badWrite,
    output logic mutedAtRelease,
    output logic running,
    output logic [19:0] clipLevel,
    output logic [7:0] lowReg,
    output logic [7:0] muteReg
);
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic active, addrOk, ack;
    int bitCnt, byteCnt;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        mem[SD_REG] = 8'h01;
        {sdaPull, faultLatched, badWrite, mutedAtRelease, active} = 5'h00;
    end
    assign clipLevel = {mem[CLIP_HI][5:0], mem[8'h10],
                        mem[8'h11][7:2]};
    assign lowReg = mem[8'h11];
    assign muteReg = mem[MUTE_REG];
    assign running = shutdownN && mem[SD_REG][0] && !faultLatched;
    always @(posedge ocEvent) faultLatched = 1'b1;
    always @(negedge shutdownN) faultLatched = 1'b0;
    always @(posedge shutdownN) mutedAtRelease = (mem[MUTE_REG] == MUTE_VAL);
    always @(negedge sda) if (scl === 1'b1) begin
        active = 1'b1;
        bitCnt = 0;
        byteCnt = 0;
    end
    always @(posedge sda) if (scl === 1'b1) active = 1'b0;
    always @(posedge scl) if (active && bitCnt < 8) begin
        sh = {sh[6:0], sda};
        bitCnt++;
    end
    always @(negedge scl) if (active) begin
        if (bitCnt == 8) begin
            ack = (byteCnt == 0) ? (sh[7:1] == ADDR && !sh[0]) : addrOk;
            if (byteCnt == 0) addrOk = ack;
            else if (byteCnt == 1) ptr = sh;
            else if (addrOk) begin
                mem[ptr] = sh;
                // Only the mute register may change while the amplifier runs.
                if (shutdownN && ptr != MUTE_REG) badWrite = 1'b1;
            end
            sdaPull = ack;
            bitCnt = 9;
            byteCnt++;
        end else if (bitCnt == 9) begin
            sdaPull = 1'b0;
            bitCnt = 0;
        end
    end
endmodule // amp_device_model
`default_nettype wire

// file: tb/test_amp_soft_control_sequencing.sv
// Self-checking bench of the amplifier bring-up controller.
`timescale 1ns/1ps
`default_nettype none
`include "amp_seq_regs.vh"
module test_amp_soft_control_sequencing;
    localparam logic [6:0] DEV_ADDR = 7'h2C;
    localparam logic [7:0] MUTE_REG = 8'h07;
    localparam logic [7:0] CLIP_HI = 8'h0F;
    localparam logic [7:0] MUTE_VAL = 8'h11;
    localparam logic [7:0] UNMUTE_VAL = 8'h00;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic supplyGood = 1'b0, ocEvent = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, sdaOut, sdaOe, sclOut, sclOe;
    wire supplyEnable, audioClockEnable, speakerShutdownN;
    wire [1:0] gainSel;
    wire devSdaPull, faultLatched, badWrite, mutedAtRelease, running;
    wire [19:0] clipLevel;
    wire [7:0] lowReg, muteReg;
    // Both lines are open drain with pull-ups.
    wire sda = !(sdaOe || devSdaPull);
    wire scl = !sclOe;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] rd, clipWord;
    logic err;
    logic [7:0] badAddr;

    amp_soft_control_sequencing i_dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata), .pready_r(pready), .pslverr_r(pslverr),
        .supplyGood(supplyGood), .overcurrentFault(faultLatched),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut),
        .sclOe(sclOe), .supplyEnable_r(supplyEnable),
        .audioClockEnable_r(audioClockEnable),
        .speakerShutdownN_r(speakerShutdownN), .speakerGainSelect_r(gainSel));
    amp_device_model #(.ADDR(DEV_ADDR), .MUTE_REG(MUTE_REG),
        .CLIP_HI(CLIP_HI), .MUTE_VAL(MUTE_VAL)) i_device (.scl(scl),
        .sda(sda), .shutdownN(speakerShutdownN), .ocEvent(ocEvent),
        .sdaPull(devSdaPull), .faultLatched(faultLatched),
        .badWrite(badWrite), .mutedAtRelease(mutedAtRelease),
        .running(running), .clipLevel(clipLevel), .lowReg(lowReg),
        .muteReg(muteReg));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic apbXfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic checkVal(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic checkReg(input logic [7:0] a, input logic [31:0] exp,
                            input logic expErr);
        apbXfer(1'b0, a, 32'h0);
        checkVal("read data", exp, rd);
        checkVal("slave error", {31'h0, expErr}, {31'h0, err});
    endtask

    // Polls the state field; the caller compares the last reading.
    task automatic waitState(input logic [3:0] s);
        for (int i = 0; i < 400; i++) begin
            apbXfer(1'b0, `OFS_STATUS, 32'h0);
            if (rd[`STAT_STATE_HI:0] === s) break;
            repeat (500) @(posedge clk);
        end
    endtask

    initial begin
        clipWord = $urandom(26154);
        badAddr = 8'h14 + 8'(($urandom % 59) * 4);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) checkReg(8'(i * 4), 32'h0, 1'b0);
        checkReg(badAddr, 32'h0, 1'b1);
        apbXfer(1'b1, `OFS_CLIP, clipWord);
        checkReg(`OFS_CLIP, {12'h0, clipWord[19:0]}, 1'b0);
        apbXfer(1'b1, `OFS_DEVCFG, {8'h0, MUTE_REG, CLIP_HI, 1'b0, DEV_ADDR});
        apbXfer(1'b1, `OFS_MUTECFG, {16'h0, UNMUTE_VAL, MUTE_VAL});
        $display("test registers done");
        apbXfer(1'b1, `OFS_CTRL, 32'h1);
        repeat (50) @(posedge clk);
        checkVal("clock enable", 32'h0, {31'h0, audioClockEnable});
        checkVal("shutdown pin", 32'h0, {31'h0, speakerShutdownN});
        checkVal("gain strap", 32'h3, {30'h0, gainSel});
        checkReg(`OFS_STATUS, 32'h11, 1'b0);
        supplyGood <= 1'b1;
        waitState(4'h6);
        checkVal("status", 32'h6, rd);
        checkVal("clip level", {12'h0, clipWord[19:0]},
            {12'h0, clipLevel});
        checkVal("low spare bits", 32'h0, {30'h0, lowReg[1:0]});
        checkVal("muted at release", 32'h1,
            {31'h0, mutedAtRelease});
        checkVal("mute register", {24'h0, UNMUTE_VAL},
            {24'h0, muteReg});
        checkVal("running", 32'h1, {31'h0, running});
        $display("test bring-up done");
        @(posedge clk);
        ocEvent <= 1'b1;
        @(posedge clk);
        ocEvent <= 1'b0;
        checkVal("running in fault", 32'h0, {31'h0, running});
        checkReg(`OFS_STATUS, 32'h46, 1'b0);
        apbXfer(1'b1, `OFS_CTRL, 32'h4);
        repeat (20) @(posedge clk);
        waitState(4'h6);
        checkVal("status after recover", 32'h6, rd);
        checkVal("running after recover", 32'h1,
            {31'h0, running});
        $display("test fault recovery done");
        apbXfer(1'b1, `OFS_CTRL, 32'h2);
        repeat (20) @(posedge clk);
        waitState(4'h0);
        checkVal("status after down", 32'h0, rd);
        checkVal("mute register", {24'h0, MUTE_VAL},
            {24'h0, muteReg});
        checkVal("pins after down", 32'h0, {27'h0, sdaOut, sclOut,
            supplyEnable, audioClockEnable, speakerShutdownN});
        checkVal("running after down", 32'h0, {31'h0, running});
        checkVal("write while running", 32'h0, {31'h0, badWrite});
        $display("test power-down done");
        finish_test();
    end

    initial begin
        repeat (110000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule // test_amp_soft_control_sequencing
`default_nettype wire
